// ---- bench/pdm_map_bench.sv ----
// self-checking bench for the memory map block
`timescale 1ns/1ps
module pdm_map_bench;
  logic        CORE_CLK = '0, RST_N = '0, PC_INC = '0, PC_LOAD = '0, INT_TAKE = '0;
  logic        BANK_SELECT_BIT = '0, DATA_RD = '0, DATA_WR = '0;
  logic [12:0] PC_LOAD_VAL = '0;
  logic [7:0]  FILE_SELECT_POINTER = '0, DATA_WDATA = '0, SPECIAL_REG_RDATA = 8'h77;
  logic [6:0]  DATA_ADDR = '0;
  wire  [12:0] PC;
  wire  [10:0] PROG_ADDR;
  wire  [7:0]  DATA_RDATA, SPECIAL_REG_ADDR, SPECIAL_REG_WDATA;
  wire         DATA_RVALID, SPECIAL_REG_SEL, SPECIAL_REG_WR;
  int          error_cnt = 0, check_count = 0;
  pdm_map DUT (.*);
  initial forever #5 CORE_CLK = ~CORE_CLK;
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [12:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // one pc control cycle, then the registered pc and fetch address
  task automatic pc_step(input logic i, l, input logic [12:0] v, e);
    @(posedge CORE_CLK);
    INT_TAKE <= i;
    PC_LOAD <= l;
    PC_LOAD_VAL <= v;
    PC_INC <= ~i & ~l;
    @(posedge CORE_CLK);
    {INT_TAKE, PC_LOAD, PC_INC} <= 3'h0;
    #1 cmp("pc", e, PC);
    cmp("prog_addr", {2'h0, e[10:0]}, {2'h0, PROG_ADDR});
  endtask
  // single-cycle access; a read is judged one cycle later
  task automatic acc(input logic w, b, input logic [6:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    DATA_WR <= w;
    DATA_RD <= ~w;
    BANK_SELECT_BIT <= b;
    DATA_ADDR <= a;
    DATA_WDATA <= d;
    @(posedge CORE_CLK);
    {DATA_WR, DATA_RD} <= 2'h0;
    #1 if (!w) cmp("rvalid", 13'h0001, {12'h000, DATA_RVALID});
    if (!w) cmp("rdata", {5'h00, d}, {5'h00, DATA_RDATA});
  endtask
  task automatic t_pc;
    pc_step(1'b1, 1'b0, 13'h0000, 13'h0004);
    pc_step(1'b0, 1'b0, 13'h0000, 13'h0005);
    pc_step(1'b0, 1'b1, 13'h1FFF, 13'h1FFF);
    pc_step(1'b0, 1'b0, 13'h0000, 13'h0000);
    pc_step(1'b0, 1'b1, 13'h0804, 13'h0804);
  endtask
  // special register write strobes stand one cycle; ram writes never raise them
  task automatic t_special_wr;
    @(posedge CORE_CLK);
    DATA_WR <= 1'b1;
    BANK_SELECT_BIT <= 1'b0;
    DATA_ADDR <= 7'h0B;
    DATA_WDATA <= 8'hC3;
    @(posedge CORE_CLK);
    DATA_ADDR <= 7'h30;
    #1 cmp("special_wr", 13'h0001, {12'h000, SPECIAL_REG_WR});
    cmp("special_sel", 13'h0001, {12'h000, SPECIAL_REG_SEL});
    cmp("special_wdata", 13'h00C3, {5'h00, SPECIAL_REG_WDATA});
    cmp("special_addr", 13'h000B, {5'h00, SPECIAL_REG_ADDR});
    @(posedge CORE_CLK);
    DATA_WR <= 1'b0;
    #1 cmp("ram_wr_strobe", 13'h0000, {12'h000, SPECIAL_REG_WR});
    cmp("ram_sel_strobe", 13'h0000, {12'h000, SPECIAL_REG_SEL});
  endtask
  // bank 1 writes land in its own cells, the mirror, or nowhere
  task automatic t_ram;
    acc(1'b1, 1'b0, 7'h20, 8'hA5);
    acc(1'b1, 1'b1, 7'h20, 8'h5A);
    acc(1'b1, 1'b1, 7'h70, 8'h3C);
    acc(1'b1, 1'b1, 7'h40, 8'hFF);
    acc(1'b0, 1'b0, 7'h20, 8'hA5);
    acc(1'b0, 1'b1, 7'h20, 8'h5A);
    acc(1'b0, 1'b0, 7'h70, 8'h3C);
    acc(1'b0, 1'b1, 7'h40, 8'h00);
    acc(1'b0, 1'b0, 7'h40, 8'h00);
    @(posedge CORE_CLK) FILE_SELECT_POINTER <= 8'hA0;
    acc(1'b0, 1'b0, 7'h00, 8'h5A);
    acc(1'b0, 1'b1, 7'h05, 8'h77);
    cmp("special_addr", 13'h0085, {5'h00, SPECIAL_REG_ADDR});
  endtask
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    #1 cmp("reset pc", 13'h0000, PC);
    t_pc;
    t_ram;
    t_special_wr;
    end_sim;
  end
  initial begin
    #20000 error_cnt++;
    end_sim;
  end
endmodule

// ---- bench/pdm_map_chk.sv ----
// port checker for the memory map block
`timescale 1ns/1ps
module pdm_map_chk (
  input wire        CORE_CLK,
  input wire        RST_N,
  input wire        PC_INC,
  input wire        PC_LOAD,
  input wire        INT_TAKE,
  input wire [12:0] PC_LOAD_VAL,
  input wire [12:0] PC,
  input wire [10:0] PROG_ADDR,
  input wire        BANK_SELECT_BIT,
  input wire [6:0]  DATA_ADDR,
  input wire        DATA_RD,
  input wire        DATA_WR,
  input wire [7:0]  DATA_RDATA,
  input wire        DATA_RVALID,
  input wire        SPECIAL_REG_SEL,
  input wire        SPECIAL_REG_WR,
  input wire [7:0]  SPECIAL_REG_ADDR
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // interrupt wins over branch and step
  a_int_vector: assert property (INT_TAKE |=> PC == 13'h0004) else $error("int vec");
  a_pc_load: assert property (!INT_TAKE && PC_LOAD |=> PC == $past(PC_LOAD_VAL))
    else $error("pc load");
  a_pc_count: assert property (!INT_TAKE && !PC_LOAD && PC_INC |=> PC == $past(PC) + 13'h0001)
    else $error("pc step");
  a_fetch_wrap: assert property (PROG_ADDR == PC[10:0]) else $error("fetch addr");
  a_read_answer: assert property (DATA_RD |=> DATA_RVALID) else $error("no rvalid");
  // bank 1 hole at C0h-EFh has no cells behind it
  a_unimpl_zero: assert property (DATA_RD && BANK_SELECT_BIT && DATA_ADDR >= 7'h40 &&
    DATA_ADDR < 7'h70 |=> DATA_RDATA == 8'h00) else $error("hole not zero");
  a_special_route: assert property (DATA_RD && DATA_ADDR != 7'h00 && DATA_ADDR < 7'h20 |=>
    SPECIAL_REG_SEL && SPECIAL_REG_ADDR == {$past(BANK_SELECT_BIT), $past(DATA_ADDR)})
    else $error("special route");
  a_ram_not_special: assert property ((DATA_RD || DATA_WR) && DATA_ADDR >= 7'h20 |=> !SPECIAL_REG_SEL)
    else $error("ram as special");
  a_special_write: assert property (DATA_WR && DATA_ADDR != 7'h00 && DATA_ADDR < 7'h20 |=>
    SPECIAL_REG_WR) else $error("special write");
  c_int: cover property (INT_TAKE);
  c_special: cover property (SPECIAL_REG_SEL);
  c_special_wr: cover property (SPECIAL_REG_WR);
  c_hole: cover property (DATA_RD && BANK_SELECT_BIT && DATA_ADDR == 7'h40);
endmodule
bind pdm_map pdm_map_chk u_chk (.*);

// ---- design/pdm_consts.vh ----
// constants for the program and data memory map block
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH
`define PDM_PC_W         13
`define PDM_PROG_AW      11
`define PDM_PROG_DW      14
`define PDM_RESET_VEC    13'h0000
`define PDM_INT_VEC      13'h0004
`define PDM_DATA_AW      7
`define PDM_DW           8
`define PDM_SPECIAL_TOP  7'h1F
`define PDM_RAM0_LO      7'h20
`define PDM_RAM1_LO      7'h20
`define PDM_RAM1_HI      7'h3F
`define PDM_MIRROR_LO    7'h70
`define PDM_RAM_WORDS    128
`define PDM_RAM_AW       7
`define PDM_RAM1_BASE    7'h60
`define PDM_ZERO8        8'h00
`define PDM_INDIRECT_OFS 7'h00
`endif

// ---- design/pdm_map.v ----
// program counter and banked data memory decoder with general purpose ram
// Function
// [RULE1] program counter is thirteen bits wide
// [RULE2] fetches above 2k words wrap around
// [RULE3] reset loads program counter with zero
// [RULE4] interrupt loads program counter with four
// [RULE5] data memory split into two banks
// [RULE6] lowest 32 addresses per bank are registers
// [RULE7] ram at 20h-7Fh bank0, A0h-BFh bank1
// [RULE8] bank1 F0h-FFh maps to bank0 70h-7Fh
// [RULE9] unimplemented reads zero, writes ignored
// [RULE10] status bank bit selects bank for direct
// [RULE11] software keeps reserved bank bits zero
// [RULE12] indirect access uses file select pointer
// [RULE13] bank bit zero bank0, one bank1
`timescale 1ns/1ps
`include "pdm_consts.vh"
module pdm_map #(
  parameter PC_W = `PDM_PC_W,
  parameter AW   = `PDM_DATA_AW,
  parameter DW   = `PDM_DW
) (
  input  wire            CORE_CLK,
  input  wire            RST_N,
  // program counter control
  input  wire            PC_INC,
  input  wire            PC_LOAD,
  input  wire [PC_W-1:0] PC_LOAD_VAL,
  input  wire            INT_TAKE,
  output reg  [PC_W-1:0] PC,
  output reg  [`PDM_PROG_AW-1:0] PROG_ADDR,
  // data access from core
  input  wire            BANK_SELECT_BIT,
  input  wire [DW-1:0]   FILE_SELECT_POINTER,
  input  wire [AW-1:0]   DATA_ADDR,
  input  wire            DATA_RD,
  input  wire            DATA_WR,
  input  wire [DW-1:0]   DATA_WDATA,
  output reg  [DW-1:0]   DATA_RDATA,
  output reg             DATA_RVALID,
  // special function register access handed outward
  output reg             SPECIAL_REG_SEL,
  output reg             SPECIAL_REG_WR,
  output reg  [DW-1:0]   SPECIAL_REG_ADDR,
  output reg  [DW-1:0]   SPECIAL_REG_WDATA,
  input  wire [DW-1:0]   SPECIAL_REG_RDATA
);
  // --------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------
  // classify an 8-bit file address: 0 none, 1 special register, 2 ram
  function [1:0] region;
    input [DW-1:0] fa;
    begin
      if (fa[AW-1:0] <= `PDM_SPECIAL_TOP)
        region = 2'h1; // [RULE6]
      else if (!fa[AW])
        region = 2'h2; // [RULE7]
      else if (fa[AW-1:0] <= `PDM_RAM1_HI)
        region = 2'h2; // [RULE7]
      else if (fa[AW-1:0] >= `PDM_MIRROR_LO)
        region = 2'h2; // [RULE8]
      else
        region = 2'h0; // [RULE9]
    end
  endfunction

  // physical ram index: bank0 20h-7Fh -> 00h-5Fh, bank1 A0h-BFh -> 60h-7Fh
  function [`PDM_RAM_AW-1:0] ram_index;
    input [DW-1:0] fa;
    begin
      if (!fa[AW] || fa[AW-1:0] >= `PDM_MIRROR_LO)
        ram_index = fa[AW-1:0] - `PDM_RAM0_LO; // [RULE8]
      else
        ram_index = fa[AW-1:0] - `PDM_RAM1_LO + `PDM_RAM1_BASE;
    end
  endfunction

  // --------------------------------------------------------------
  // program counter
  // --------------------------------------------------------------
  reg [PC_W-1:0] next_pc;

  // interrupt has priority over a branch load, which beats increment
  always @* begin
    next_pc = PC;
    if (INT_TAKE)
      next_pc = `PDM_INT_VEC; // [RULE4]
    else if (PC_LOAD)
      next_pc = PC_LOAD_VAL;
    else if (PC_INC)
      next_pc = PC + {{(PC_W-1){1'b0}}, 1'b1}; // [RULE1]
  end

  // fetch address keeps only the implemented low bits, so high pages alias
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PC <= `PDM_RESET_VEC; // [RULE3]
      PROG_ADDR <= {`PDM_PROG_AW{1'b0}};
    end else begin
      PC <= next_pc;
      PROG_ADDR <= next_pc[`PDM_PROG_AW-1:0]; // [RULE2]
    end
  end

  // --------------------------------------------------------------
  // data address formation
  // --------------------------------------------------------------
  reg  [DW-1:0] file_addr;
  wire [1:0]    reg_kind;
  wire [`PDM_RAM_AW-1:0] ridx;
  wire [DW-1:0] ram_rdata;
  wire          ram_we;

  // indirect slot uses the pointer, otherwise bank bit plus 7-bit address;
  // reserved bank bits assumed zero, so only one bank bit enters here
  always @* begin
    if (DATA_ADDR == `PDM_INDIRECT_OFS)
      file_addr = FILE_SELECT_POINTER; // [RULE12]
    else
      file_addr = {BANK_SELECT_BIT, DATA_ADDR}; // [RULE10] [RULE13] [RULE5] [RULE11]
  end

  assign reg_kind = region(file_addr);
  assign ridx     = ram_index(file_addr);
  assign ram_we   = DATA_WR && (reg_kind == 2'h2); // [RULE9]

  pdm_ram #(
    .WORDS(`PDM_RAM_WORDS),
    .AW   (`PDM_RAM_AW),
    .DW   (DW)
  ) u_ram (
    .clk  (CORE_CLK),
    .rst_n(RST_N),
    .we   (ram_we),
    .waddr(ridx),
    .wdata(DATA_WDATA),
    .raddr(ridx),
    .rdata(ram_rdata)
  );

  // --------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------
  // special register strobes follow request by one cycle; their read data
  // is sampled in the request cycle, so that side must answer combinationally
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DATA_RDATA        <= `PDM_ZERO8;
      DATA_RVALID       <= 1'b0;
      SPECIAL_REG_SEL   <= 1'b0;
      SPECIAL_REG_WR    <= 1'b0;
      SPECIAL_REG_ADDR  <= `PDM_ZERO8;
      SPECIAL_REG_WDATA <= `PDM_ZERO8;
    end else begin
      DATA_RVALID       <= DATA_RD;
      SPECIAL_REG_SEL   <= (DATA_RD || DATA_WR) && (reg_kind == 2'h1); // [RULE6]
      SPECIAL_REG_WR    <= DATA_WR && (reg_kind == 2'h1);
      SPECIAL_REG_ADDR  <= file_addr;
      SPECIAL_REG_WDATA <= DATA_WDATA;
      if (DATA_RD) begin
        case (reg_kind)
          2'h1:    DATA_RDATA <= SPECIAL_REG_RDATA;
          2'h2:    DATA_RDATA <= ram_rdata;
          default: DATA_RDATA <= `PDM_ZERO8; // [RULE9]
        endcase
      end
    end
  end
endmodule

// ---- design/pdm_ram.v ----
// general purpose ram storage, flip-flop array addressed by index
`timescale 1ns/1ps
`include "pdm_consts.vh"
module pdm_ram #(
  parameter WORDS = `PDM_RAM_WORDS,
  parameter AW    = `PDM_RAM_AW,
  parameter DW    = `PDM_DW
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output wire [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:WORDS-1];
  integer i;

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  // cleared at reset so reads are defined before the first write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        mem[i] <= {DW{1'b0}};
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule
